// file: fcag_crc_step.sv
// One-byte CRC-16 update, MSB first.
// Assumes the caller registers the result; purely combinational.
`default_nettype none
module fcag_crc_step #(
  parameter logic [15:0] POLY = 16'h1021
) (
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data_in,
  output logic [15:0] crc_out
);
  always_comb begin
    logic [15:0] c;
    c = crc_in ^ {data_in, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ POLY) : (c << 1);
    end
    crc_out = c;
  end
endmodule : fcag_crc_step
`default_nettype wire

// file: fcag_flash_model.sv
// Flash array model answering byte reads issued by the check engine.
// Assumes flash_rd pulses for one cycle; flash_rvalid follows LAT+1 cycles after the pulse.
`default_nettype none
module fcag_flash_model #(
  parameter int LAT = 2
) (
  input wire logic clk,
  input wire logic flash_rd,
  input wire logic [19:0] flash_addr,
  output logic flash_rvalid,
  output logic [7:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic [19:0] a = 20'h00000;
  // Single driver per output; the engine ignores both until it reads
  always @(posedge clk) begin
    flash_rvalid <= 1'b0;
    // Toggle while idle so stale data never looks like a good byte
    flash_rdata <= ~flash_rdata;
    if (flash_rd) begin
      a <= flash_addr;
      cnt <= LAT;
    end else if (cnt == 1) begin
      cnt <= 0;
      flash_rvalid <= 1'b1;
      flash_rdata <= a[7:0] ^ a[15:8] ^ 8'h5a;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : fcag_flash_model
`default_nettype wire

// file: fcag_pkg.sv
// Package: shared constants for the flash check and access guard block.
// Assumes a 20-bit CPU byte address space and one 100 MHz system clock.
`default_nettype none
package fcag_pkg;
  localparam int ADDR_W = 20;
  // Register byte addresses
  localparam logic [19:0] GUARD_CTRL_ADDR = 20'hf0078;
  localparam logic [19:0] CHECK_CTRL_ADDR = 20'hf02f0;
  localparam logic [19:0] CHECK_RES_ADDR = 20'hf02f2;
  // Reset values
  localparam logic [7:0] GUARD_CTRL_RST = 8'h00;
  localparam logic [7:0] CHECK_CTRL_RST = 8'h00;
  localparam logic [15:0] CHECK_RES_RST = 16'h0000;
  // Check control fields
  localparam int CHK_EN_BIT = 7;
  localparam int SPAN_LSB = 0;
  localparam int SPAN_W = 4;
  localparam logic [7:0] CHECK_CTRL_MASK = 8'h8f;
  // Guard control fields
  localparam int DET_EN_BIT = 7;
  localparam int RAMG_LSB = 4;
  localparam int PORTG_BIT = 2;
  localparam int IRQG_BIT = 1;
  localparam int CLKG_BIT = 0;
  localparam logic [7:0] GUARD_CTRL_MASK = 8'hb7;
  // Memory map
  localparam logic [19:0] FLASH_END = 20'h40000;
  localparam logic [19:0] SFR_BASE = 20'hf0000;
  localparam logic [19:0] RAM_BASE = 20'hf9f00;
  localparam int SPAN_UNIT_SH = 14;
  localparam logic [19:0] EXPECT_BYTES = 20'h00004;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  typedef enum logic [3:0] {
    FCAG_IDLE = 4'h1,
    FCAG_READ = 4'h2,
    FCAG_WAIT = 4'h4,
    FCAG_DONE = 4'h8
  } fcag_state_t;
endpackage : fcag_pkg
`default_nettype wire

// file: fcag_top.sv
// Flash CRC engine and invalid-access / RAM write guard.
// Assumes CPU register accesses and access monitor inputs are synchronous
// to clk; flash answers a read with flash_rvalid one or more cycles later.
`default_nettype none
// Operation
// RULE1 - Enable bit gates start on HALT
// RULE2 - Span ends at (n+1)*16K minus 4
// RULE3 - Software stores expected CRC beside span
// RULE4 - Computed CRC lands in 16-bit result
// RULE5 - Result writes ignored unless enable set
// RULE6 - Software uses 16-bit result accesses
// RULE7 - Control accepts bit and byte writes
// RULE8 - Engine reads flash only
// RULE9 - HALT must run from RAM
// RULE10 - Reset clears result to zero
// RULE11 - Reset clears guard control to zero
// RULE12 - Software uses byte guard accesses
// RULE13 - Guard field selects 0/128/256/512 bytes
// RULE14 - Guarded RAM starts at RAM base
// RULE15 - Prohibited access raises internal reset
// RULE16 - Reads/fetches past flash end invalid
// RULE17 - Guard control bit layout
// RULE18 - Store result then release HALT
// RULE19 - Guarded writes dropped, reads allowed
module fcag_top
  import fcag_pkg::*;
#(
  parameter int SPAN_BITS = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [fcag_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wide,
  input wire logic reg_bit_op,
  input wire logic [2:0] reg_bit_idx,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic cpu_halt_ram,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_fetch,
  input wire logic [fcag_pkg::ADDR_W-1:0] acc_addr,
  input wire logic flash_rvalid,
  input wire logic [7:0] flash_rdata,
  output logic flash_rd,
  output logic [fcag_pkg::ADDR_W-1:0] flash_addr,
  output logic ram_wr_block,
  output logic bad_access_reset,
  output logic halt_release,
  output logic check_busy
);
  import fcag_pkg::*;

  logic [7:0] check_ctrl_r;
  logic [7:0] guard_ctrl_r;
  logic [15:0] check_res_r;
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic [19:0] addr_r;
  logic [19:0] last_addr;
  logic flash_rd_r;
  logic ram_wr_block_r;
  logic bad_access_r;
  logic halt_release_r;
  logic busy_r;
  logic [15:0] rdata_r;
  fcag_state_t state_r;

  // Byte or single-bit write merge for 8-bit registers
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] mask,
                                       input logic bit_op, input logic [2:0] idx,
                                       input logic [7:0] wd);
    logic [7:0] v;
    v = old;
    if (bit_op) begin
      v[idx] = wd[0];
    end else begin
      v = wd;
    end
    return v & mask;
  endfunction : merge8

  function automatic logic hit(input logic [19:0] a, input logic [19:0] base);
    return a == base;
  endfunction : hit

  wire logic wr_ctrl = reg_wr && hit(reg_addr, CHECK_CTRL_ADDR);
  wire logic wr_guard = reg_wr && hit(reg_addr, GUARD_CTRL_ADDR) && !reg_wide;
  wire logic wr_res = reg_wr && hit(reg_addr, CHECK_RES_ADDR) && reg_wide;
  wire logic chk_en = check_ctrl_r[CHK_EN_BIT];
  wire logic [SPAN_BITS-1:0] span_sel = check_ctrl_r[SPAN_LSB +: SPAN_BITS];

  // Last byte checked; expected value sits in the 4 bytes after it
  assign last_addr = 20'(({16'h0000, span_sel} + 20'h1) << SPAN_UNIT_SH)
                     - EXPECT_BYTES - 20'h1; // RULE2 RULE3

  fcag_crc_step #(.POLY(CRC_POLY)) u_step (
    .crc_in(crc_r),
    .data_in(flash_rdata),
    .crc_out(crc_nxt)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      check_ctrl_r <= CHECK_CTRL_RST;
    end else if (wr_ctrl) begin
      check_ctrl_r <= merge8(check_ctrl_r, CHECK_CTRL_MASK, reg_bit_op, reg_bit_idx,
                             reg_wdata[7:0]); // RULE7
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      guard_ctrl_r <= GUARD_CTRL_RST; // RULE11
    end else if (wr_guard) begin
      guard_ctrl_r <= reg_wdata[7:0] & GUARD_CTRL_MASK; // RULE17
    end
  end

  // Engine completion wins over a simultaneous software write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      check_res_r <= CHECK_RES_RST; // RULE10
    end else if (state_r == FCAG_DONE) begin
      check_res_r <= crc_r; // RULE4 RULE18
    end else if (wr_res && chk_en) begin
      check_res_r <= reg_wdata; // RULE5
    end
  end

  // CRC sequencer; flash reads only, one byte at a time
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= FCAG_IDLE;
      addr_r <= 20'h00000;
      crc_r <= CRC_INIT;
      flash_rd_r <= 1'b0;
      halt_release_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      flash_rd_r <= 1'b0;
      halt_release_r <= 1'b0;
      case (state_r)
        FCAG_IDLE: begin
          if (chk_en && cpu_halt_ram) begin // RULE1 RULE9
            state_r <= FCAG_READ;
            addr_r <= 20'h00000;
            crc_r <= CRC_INIT;
            busy_r <= 1'b1;
          end
        end
        FCAG_READ: begin
          flash_rd_r <= 1'b1; // RULE8
          state_r <= FCAG_WAIT;
        end
        FCAG_WAIT: begin
          if (flash_rvalid) begin
            crc_r <= crc_nxt;
            if (addr_r == last_addr) begin
              state_r <= FCAG_DONE;
            end else begin
              addr_r <= addr_r + 20'h1;
              state_r <= FCAG_READ;
            end
          end
        end
        FCAG_DONE: begin
          halt_release_r <= 1'b1; // RULE18
          state_r <= FCAG_IDLE;
          busy_r <= 1'b0;
        end
        default: begin
          state_r <= FCAG_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // Guard size in bytes from the 2-bit field
  function automatic logic [19:0] guard_len(input logic [1:0] sel);
    case (sel)
      2'h1: return 20'h00080;
      2'h2: return 20'h00100;
      2'h3: return 20'h00200;
      default: return 20'h00000;
    endcase
  endfunction : guard_len

  wire logic [19:0] glen = guard_len(guard_ctrl_r[RAMG_LSB +: 2]); // RULE13
  wire logic in_guard = (acc_addr >= RAM_BASE) && (acc_addr < RAM_BASE + glen); // RULE14
  wire logic past_flash = (acc_addr >= FLASH_END) && (acc_addr < SFR_BASE);
  wire logic fetch_bad = acc_fetch && (acc_addr >= FLASH_END) && (acc_addr < RAM_BASE);

  // Registered: memory must hold the write commit one cycle for the verdict
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ram_wr_block_r <= 1'b0;
      bad_access_r <= 1'b0;
    end else begin
      ram_wr_block_r <= acc_valid && acc_write && in_guard; // RULE19
      bad_access_r <= guard_ctrl_r[DET_EN_BIT] && acc_valid && !acc_write &&
                      (past_flash || fetch_bad); // RULE15 RULE16
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      if (hit(reg_addr, CHECK_CTRL_ADDR)) begin
        rdata_r <= {8'h00, check_ctrl_r};
      end else if (hit(reg_addr, GUARD_CTRL_ADDR)) begin
        rdata_r <= {8'h00, guard_ctrl_r};
      end else if (hit(reg_addr, CHECK_RES_ADDR)) begin
        rdata_r <= check_res_r;
      end else begin
        rdata_r <= 16'h0000;
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign flash_rd = flash_rd_r;
  assign flash_addr = addr_r;
  assign ram_wr_block = ram_wr_block_r;
  assign bad_access_reset = bad_access_r;
  assign halt_release = halt_release_r;
  // Busy tracks the state flops but comes from its own flop
  assign check_busy = busy_r;

  AST_NO_START: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == FCAG_IDLE && !chk_en) |=> state_r == FCAG_IDLE) // RULE1
    else $error("engine left idle while disabled");
  AST_START: assert property (@(posedge clk) disable iff (!resetn) // RULE1
    (state_r == FCAG_IDLE && chk_en && cpu_halt_ram) |=> ##1 flash_rd && flash_addr == 20'h0)
    else $error("run did not start at address zero");
  AST_SPAN: assert property (@(posedge clk) disable iff (!resetn)
    flash_rd |-> flash_addr <= last_addr) // RULE2
    else $error("read beyond selected span");
  AST_FLASH_ONLY: assert property (@(posedge clk) disable iff (!resetn)
    flash_rd |-> flash_addr < FLASH_END) // RULE8
    else $error("engine read outside flash");
  AST_RES_LOCK: assert property (@(posedge clk) disable iff (!resetn)
    (wr_res && !chk_en && state_r != FCAG_DONE) |=> $stable(check_res_r)) // RULE5
    else $error("result written while disabled");
  AST_DONE: assert property (@(posedge clk) disable iff (!resetn)
    state_r == FCAG_DONE |=> halt_release && check_res_r == $past(crc_r)) // RULE18
    else $error("result or release missing at end");
  AST_CTRL_LAYOUT: assert property (@(posedge clk) disable iff (!resetn) // RULE17
    check_ctrl_r[6:4] == 3'h0 && guard_ctrl_r[6] == 1'b0 && guard_ctrl_r[3] == 1'b0)
    else $error("reserved control bits set");
  AST_GUARD: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && acc_write && guard_ctrl_r[5:4] == 2'h1 && acc_addr == RAM_BASE + 20'h7f)
    |=> ram_wr_block) // RULE13
    else $error("guarded write not blocked");
  AST_GUARD_READ: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && !acc_write) |=> !ram_wr_block) // RULE19
    else $error("read was blocked");
  AST_BAD: assert property (@(posedge clk) disable iff (!resetn)
    (acc_valid && !acc_write && guard_ctrl_r[7] && acc_addr == FLASH_END)
    |=> bad_access_reset) // RULE16
    else $error("invalid read not caught");
  AST_NO_BAD: assert property (@(posedge clk) disable iff (!resetn)
    !guard_ctrl_r[7] |=> !bad_access_reset) // RULE15
    else $error("reset raised with detection off");
endmodule : fcag_top
`default_nettype wire

// file: test_fcag_top.sv
// Self-checking bench for the flash check engine and access guard.
// Assumes the flash model answers every read; inputs change at negedge.
`default_nettype none
module test_fcag_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fcag_pkg::*;
  typedef struct packed {
    logic [7:0] g;
    logic w;
    logic f;
    logic [19:0] a;
    logic blk;
    logic rst;
  } fcag_row_t;
  logic clk, resetn, reg_wr, reg_rd, reg_wide, reg_bit_op, cpu_halt_ram;
  logic acc_valid, acc_write, acc_fetch, flash_rvalid, flash_rd;
  logic ram_wr_block, bad_access_reset, halt_release, check_busy;
  logic [19:0] reg_addr, acc_addr, flash_addr;
  logic [2:0] reg_bit_idx;
  logic [15:0] reg_wdata, reg_rdata;
  logic [7:0] flash_rdata;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int nreads = 0;
  logic bad_addr = 1'b0;
  fcag_row_t rows [12] = '{
    '{8'h80, 1'b0, 1'b0, 20'h40000, 1'b0, 1'b1},
    '{8'h80, 1'b0, 1'b0, 20'h3ffff, 1'b0, 1'b0},
    '{8'h80, 1'b0, 1'b1, 20'hf9eff, 1'b0, 1'b1},
    '{8'h80, 1'b0, 1'b1, 20'hf9f00, 1'b0, 1'b0},
    '{8'h80, 1'b0, 1'b0, 20'hf0000, 1'b0, 1'b0},
    '{8'h80, 1'b1, 1'b0, 20'h50000, 1'b0, 1'b0},
    '{8'h00, 1'b0, 1'b0, 20'h40000, 1'b0, 1'b0},
    '{8'h10, 1'b1, 1'b0, 20'hf9f7f, 1'b1, 1'b0},
    '{8'h10, 1'b1, 1'b0, 20'hf9f80, 1'b0, 1'b0},
    '{8'h20, 1'b1, 1'b0, 20'hf9fff, 1'b1, 1'b0},
    '{8'h30, 1'b1, 1'b0, 20'hfa100, 1'b0, 1'b0},
    '{8'h30, 1'b0, 1'b0, 20'hf9f00, 1'b0, 1'b0}
  };
  fcag_top u_fcag_top (.clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wide, .reg_bit_op,
    .reg_bit_idx, .reg_wdata, .reg_rdata, .cpu_halt_ram, .acc_valid, .acc_write, .acc_fetch,
    .acc_addr, .flash_rvalid, .flash_rdata, .flash_rd, .flash_addr, .ram_wr_block,
    .bad_access_reset, .halt_release, .check_busy);
  fcag_flash_model u_fcag_flash_model (.clk, .flash_rd, .flash_addr, .flash_rvalid,
    .flash_rdata);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic do_reset();
    resetn = 1'b0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
  endtask : do_reset
  task automatic wr(input logic [19:0] a, input logic w, input logic b, input logic [2:0] i,
                    input logic [15:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wide = w;
    reg_bit_op = b;
    reg_bit_idx = i;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [19:0] a, output logic [15:0] q);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    q = reg_rdata;
  endtask : rd
  // Reference CRC over the model's address pattern, MSB first
  function automatic logic [15:0] crc_of(input int n);
    logic [15:0] c;
    logic [7:0] d;
    c = CRC_INIT;
    for (int k = 0; k < n; k++) begin
      d = k[7:0] ^ k[15:8] ^ 8'h5a;
      for (int b = 7; b >= 0; b--) begin
        c = (c[15] ^ d[b]) ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction : crc_of
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (flash_rd) begin
      nreads <= nreads + 1;
      if (flash_addr >= 20'h03ffc) bad_addr <= 1'b1;
    end
    if (cycles == 90000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    logic [15:0] q;
    int n0;
    {resetn, reg_wr, reg_rd, reg_wide, reg_bit_op, cpu_halt_ram} = '0;
    {acc_valid, acc_write, acc_fetch, reg_bit_idx, reg_addr, acc_addr, reg_wdata} = '0;
    do_reset();
    rd(CHECK_RES_ADDR, q);
    chk(q, 16'h0000);
    rd(GUARD_CTRL_ADDR, q);
    chk(q, 16'h0000);
    wr(GUARD_CTRL_ADDR, 1'b0, 1'b0, 3'd0, 16'h00ff);
    rd(GUARD_CTRL_ADDR, q);
    chk(q, {8'h00, GUARD_CTRL_MASK});
    wr(GUARD_CTRL_ADDR, 1'b1, 1'b0, 3'd0, 16'h0000);
    rd(GUARD_CTRL_ADDR, q);
    chk(q, {8'h00, GUARD_CTRL_MASK});
    foreach (rows[i]) begin
      wr(GUARD_CTRL_ADDR, 1'b0, 1'b0, 3'd0, {8'h00, rows[i].g});
      @(negedge clk);
      acc_valid = 1'b1;
      acc_write = rows[i].w;
      acc_fetch = rows[i].f;
      acc_addr = rows[i].a;
      @(negedge clk);
      acc_valid = 1'b0;
      chk({15'h0000, ram_wr_block}, {15'h0000, rows[i].blk});
      chk({15'h0000, bad_access_reset}, {15'h0000, rows[i].rst});
    end
    wr(CHECK_CTRL_ADDR, 1'b0, 1'b0, 3'd0, 16'h00ff);
    rd(CHECK_CTRL_ADDR, q);
    chk(q, 16'h008f);
    wr(CHECK_CTRL_ADDR, 1'b0, 1'b1, 3'd7, 16'h0000);
    rd(CHECK_CTRL_ADDR, q);
    chk(q, 16'h000f);
    wr(CHECK_RES_ADDR, 1'b1, 1'b0, 3'd0, 16'h1234);
    rd(CHECK_RES_ADDR, q);
    chk(q, 16'h0000);
    cpu_halt_ram = 1'b1;
    @(negedge clk);
    cpu_halt_ram = 1'b0;
    repeat (3) @(negedge clk);
    chk({15'h0000, check_busy}, 16'h0000);
    wr(CHECK_CTRL_ADDR, 1'b0, 1'b1, 3'd7, 16'h0001);
    wr(CHECK_RES_ADDR, 1'b1, 1'b0, 3'd0, 16'h1234);
    rd(CHECK_RES_ADDR, q);
    chk(q, 16'h1234);
    wr(CHECK_CTRL_ADDR, 1'b0, 1'b0, 3'd0, 16'h0080);
    n0 = nreads;
    cpu_halt_ram = 1'b1;
    @(negedge clk);
    cpu_halt_ram = 1'b0;
    chk({15'h0000, check_busy}, 16'h0001);
    // Five cycles per byte with the model's latency of two
    for (int i = 0; i < 84000 && halt_release !== 1'b1; i++) begin
      @(negedge clk);
    end
    chk({15'h0000, halt_release}, 16'h0001);
    chk({15'h0000, check_busy}, 16'h0000);
    chk(16'(nreads - n0), 16'd16380);
    chk({15'h0000, bad_addr}, 16'h0000);
    rd(CHECK_RES_ADDR, q);
    chk(q, crc_of(16380));
    do_reset();
    rd(CHECK_RES_ADDR, q);
    chk(q, 16'h0000);
    rd(GUARD_CTRL_ADDR, q);
    chk(q, 16'h0000);
    wrap_up();
  end
endmodule : test_fcag_top
`default_nettype wire
